//--- hw/tpf_pkg.sv
// Package: shared constants and carrier types for the transmit front end
package tpf_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int CTL_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int LANES = 4;
    localparam int LANE0 = 0;
    localparam int REF_MHZ = 100;
    localparam int PREDIV = 2;
    localparam int PLL_MULT = 25;
    localparam int PAR_DIV = 5;
    localparam int HALF_DIV = 2;
    localparam int PLL_IN_MHZ = REF_MHZ / PREDIV;
    localparam int SERIAL_MHZ = PLL_IN_MHZ * PLL_MULT;
    localparam int PAR_MHZ = SERIAL_MHZ / PAR_DIV;
    localparam int CORE_MHZ = PAR_MHZ / HALF_DIV;
    localparam int LAT_MIN = 3;
    localparam int LAT_MAX = 4;
    localparam int STABLE_CYC = 16;
    localparam logic [4:0] STABLE_CNT_MAX = 5'h10;
    localparam logic [4:0] STABLE_CNT_ZERO = 5'h00;
    localparam logic [4:0] STABLE_CNT_ONE = 5'h01;
    localparam logic [3:0] PTR_ONE = 4'h1;
    localparam logic [3:0] PTR_ZERO = 4'h0;
    localparam logic [3:0] PTR_FULL = 4'h8;
    localparam logic [1:0] STG_ONE = 2'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef struct packed {
        logic [BYTE_W-1:0] high_byte;
        logic [BYTE_W-1:0] low_byte;
        logic high_ctl;
        logic low_ctl;
    } tpf_word_t;

    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic ctl;
    } tpf_byte_t;

    typedef enum logic [2:0] {
        TPF_HOLD = 3'h1,
        TPF_LOW = 3'h2,
        TPF_HIGH = 3'h4
    } tpf_ser_t;
endpackage : tpf_pkg

//--- hw/tpf_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tpf_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_hold,
    // Write side
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    // Read side
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic [AW:0] cnt;
    logic do_wr;
    logic do_rd;

    assign cnt = wr_ptr_reg - rd_ptr_reg;
    assign o_wr_ready = !i_hold && (cnt != (AW+1)'(DEPTH));
    assign o_rd_valid = !i_hold && (cnt != '0);
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = o_rd_valid && i_rd_ready;
    assign o_rd_data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge i_clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
        end else if (i_hold) begin
            wr_ptr_reg <= '0;
        end else if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ptr_reg <= '0;
        end else if (i_hold) begin
            rd_ptr_reg <= '0;
        end else if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
        end
    end
endmodule : tpf_fifo
`default_nettype wire

//--- hw/tpf_top.sv
// Transmit phase FIFO, byte serializer and clock enable tree
`timescale 1ns/1ps
`default_nettype none
module tpf_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Mode and reference selection
    input wire logic i_four_lane,
    input wire logic i_ref_from_pin_b,
    input wire logic i_ref_from_inter_block,
    input wire logic i_ext_wr_clock_used,
    // Reference clock sources, sampled levels
    input wire logic i_ref_clock_pin_a,
    input wire logic i_ref_clock_pin_b,
    input wire logic i_ref_inter_block,
    // Fabric word input
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    input wire tpf_pkg::tpf_word_t i_tx_word,
    // Encoder byte output
    output tpf_pkg::tpf_byte_t o_enc_byte,
    output logic o_enc_valid,
    // Clock enables and status
    output logic o_ref_selected,
    output logic o_core_clk_en,
    output logic o_core_clk_en_shared,
    output logic o_core_clk_en_lane,
    output logic o_par_clk_en,
    output logic o_wr_from_lane0,
    output logic o_clocks_stable
);
    logic half_phase_reg;
    logic [4:0] stable_cnt_reg;
    logic hold;
    logic core_en;
    logic rd_valid;
    logic rd_ready;
    logic fifo_wr_ready;
    tpf_pkg::tpf_word_t rd_word;
    tpf_pkg::tpf_word_t word_reg;
    tpf_pkg::tpf_byte_t byte_reg;
    logic byte_valid_reg;
    tpf_pkg::tpf_ser_t state_reg;
    logic [1:0] wr_age_reg;
    logic [3:0] ripe_cnt_reg;
    logic fifo_wr;
    logic fifo_rd;

    // Reference source choice, inter-block source preferred over pin B, then pin A
    always_comb begin
        if (i_ref_from_inter_block) begin
            o_ref_selected = i_ref_inter_block;
        end else if (i_ref_from_pin_b) begin
            o_ref_selected = i_ref_clock_pin_b;
        end else begin
            o_ref_selected = i_ref_clock_pin_a;
        end
    end

    // System clock stands in for the 250 MHz parallel rate scaled down;
    // the 125 MHz core rate is every other cycle of it
    assign o_par_clk_en = !hold;
    assign core_en = half_phase_reg && !hold;
    assign o_core_clk_en = core_en;
    assign o_core_clk_en_shared = core_en && i_four_lane;
    assign o_core_clk_en_lane = core_en && !i_four_lane;
    assign o_wr_from_lane0 = !i_ext_wr_clock_used;
    assign o_clocks_stable = !hold;
    assign o_tx_ready = fifo_wr_ready && core_en;

    // Divide by two of the parallel rate
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_phase_reg <= 1'b0;
        end else if (hold) begin
            half_phase_reg <= 1'b0;
        end else begin
            half_phase_reg <= !half_phase_reg;
        end
    end

    // Wait for PLL and dividers to settle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stable_cnt_reg <= tpf_pkg::STABLE_CNT_ZERO;
        end else if (stable_cnt_reg != tpf_pkg::STABLE_CNT_MAX) begin
            stable_cnt_reg <= stable_cnt_reg + tpf_pkg::STABLE_CNT_ONE;
        end
    end
    assign hold = (stable_cnt_reg != tpf_pkg::STABLE_CNT_MAX);

    // Eight-word phase compensation FIFO
    tpf_fifo #(
        .WIDTH($bits(tpf_pkg::tpf_word_t)),
        .DEPTH(tpf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_hold(hold),
        .i_wr_valid(i_tx_valid && core_en),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(i_tx_word),
        .o_rd_valid(rd_valid),
        .i_rd_ready(rd_ready),
        .o_rd_data(rd_word)
    );

    // Read pacing: each word ripens for three core cycles before it is read
    assign fifo_wr = i_tx_valid && o_tx_ready;
    assign fifo_rd = rd_ready && rd_valid;

    // Age of recent writes, shifted once per core cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_age_reg <= '0;
        end else if (hold) begin
            wr_age_reg <= '0;
        end else if (core_en) begin
            wr_age_reg <= {wr_age_reg[0], fifo_wr};
        end
    end

    // Count of stored words old enough to leave, keeps full word rate
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ripe_cnt_reg <= tpf_pkg::PTR_ZERO;
        end else if (hold) begin
            ripe_cnt_reg <= tpf_pkg::PTR_ZERO;
        end else if (core_en && wr_age_reg[1] && !fifo_rd) begin
            ripe_cnt_reg <= ripe_cnt_reg + tpf_pkg::PTR_ONE;
        end else if (fifo_rd && !wr_age_reg[1]) begin
            ripe_cnt_reg <= ripe_cnt_reg - tpf_pkg::PTR_ONE;
        end
    end
    assign rd_ready = core_en && (ripe_cnt_reg != tpf_pkg::PTR_ZERO) && (state_reg != tpf_pkg::TPF_LOW);

    // Byte serializer phase
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= tpf_pkg::TPF_HOLD;
        end else begin
            case (state_reg)
                tpf_pkg::TPF_HOLD: begin
                    if (rd_ready && rd_valid) begin
                        state_reg <= tpf_pkg::TPF_LOW;
                    end
                end
                tpf_pkg::TPF_LOW: begin
                    state_reg <= tpf_pkg::TPF_HIGH;
                end
                tpf_pkg::TPF_HIGH: begin
                    if (rd_ready && rd_valid) begin
                        state_reg <= tpf_pkg::TPF_LOW;
                    end else begin
                        state_reg <= tpf_pkg::TPF_HOLD;
                    end
                end
                default: begin
                    state_reg <= tpf_pkg::TPF_HOLD;
                end
            endcase
        end
    end

    // Word holding register on the half-rate read port
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_reg <= '0;
        end else if (rd_ready && rd_valid) begin
            word_reg <= rd_word;
        end
    end

    // Byte output at the full parallel rate
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            byte_reg <= '0;
            byte_valid_reg <= 1'b0;
        end else begin
            case (state_reg)
                tpf_pkg::TPF_LOW: begin
                    byte_reg.data <= word_reg.low_byte;
                    byte_reg.ctl <= word_reg.low_ctl;
                    byte_valid_reg <= 1'b1;
                end
                tpf_pkg::TPF_HIGH: begin
                    byte_reg.data <= word_reg.high_byte;
                    byte_reg.ctl <= word_reg.high_ctl;
                    byte_valid_reg <= 1'b1;
                end
                default: begin
                    byte_reg.data <= tpf_pkg::BYTE_ZERO;
                    byte_reg.ctl <= 1'b0;
                    byte_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    assign o_enc_byte = byte_reg;
    assign o_enc_valid = byte_valid_reg;
    // Lane placement is fixed by the instantiating wrapper
endmodule : tpf_top
`default_nettype wire

//--- verif/tpf_top_asserts.sv
// Port checker for the transmit front end
`timescale 1ns/1ps
`default_nettype none
module tpf_top_asserts (
    // Watched ports
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_four_lane,
    input wire logic i_ref_from_pin_b,
    input wire logic i_ref_from_inter_block,
    input wire logic i_ext_wr_clock_used,
    input wire logic i_ref_clock_pin_a,
    input wire logic i_ref_clock_pin_b,
    input wire logic i_ref_inter_block,
    input wire logic i_tx_valid,
    input wire logic o_tx_ready,
    input wire logic o_enc_valid,
    input wire logic o_par_clk_en,
    input wire logic o_ref_selected,
    input wire logic o_core_clk_en,
    input wire logic o_core_clk_en_shared,
    input wire logic o_core_clk_en_lane,
    input wire logic o_wr_from_lane0,
    input wire logic o_clocks_stable
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_ready_needs_en: assert property (o_tx_ready |-> o_core_clk_en)
        else $error("ready off the core enable");
    a_en_half_rate: assert property (o_clocks_stable && $past(o_clocks_stable)
        |-> o_core_clk_en != $past(o_core_clk_en)) else $error("core enable not alternating");
    a_hold_no_ready: assert property (!o_clocks_stable |-> !o_tx_ready && !o_core_clk_en)
        else $error("activity during settle hold");
    a_shared_en: assert property (o_core_clk_en_shared == (i_four_lane && o_core_clk_en))
        else $error("shared enable wrong");
    a_lane_en: assert property (o_core_clk_en_lane == (!i_four_lane && o_core_clk_en))
        else $error("lane enable wrong");
    a_lane0_write: assert property (o_wr_from_lane0 == !i_ext_wr_clock_used)
        else $error("write clock source wrong");
    a_ref_choice: assert property (o_ref_selected == (i_ref_from_inter_block ?
        i_ref_inter_block : i_ref_from_pin_b ? i_ref_clock_pin_b : i_ref_clock_pin_a))
        else $error("reference choice wrong");
    a_byte_pair: assert property ($rose(o_enc_valid) |=> o_enc_valid)
        else $error("high byte missing");
    a_write_reaches: assert property (i_tx_valid && o_tx_ready |-> ##[1:9] o_enc_valid)
        else $error("word never emitted");
    a_par_en_hold: assert property (!o_clocks_stable |-> !o_par_clk_en)
        else $error("parallel enable during hold");
endmodule : tpf_top_asserts
bind tpf_top tpf_top_asserts tpf_top_asserts_inst (.*);
`default_nettype wire

//--- verif/tpf_mac_model.sv
// Fabric-side word source feeding the transmit FIFO
`timescale 1ns/1ps
`default_nettype none
module tpf_mac_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Handshake and data
    input wire logic i_en,
    input wire logic i_tx_ready,
    output var logic o_tx_valid,
    output var tpf_pkg::tpf_word_t o_tx_word,
    output var logic [7:0] o_sent
);
    logic fire_reg;
    tpf_pkg::tpf_word_t w;
    always_comb begin
        w.low_byte = {o_sent[6:0], 1'b0};
        w.high_byte = {o_sent[6:0], 1'b1};
        w.low_ctl = o_sent[0];
        w.high_ctl = ~o_sent[0];
        o_tx_word = o_tx_valid ? w : ~w;
    end
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) fire_reg <= 1'b0;
        else fire_reg <= o_tx_valid && i_tx_ready;
    end
    always @(negedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sent <= 8'h00;
            o_tx_valid <= 1'b0;
        end else begin
            o_sent <= o_sent + {7'h00, fire_reg};
            o_tx_valid <= i_en || (o_tx_valid && !fire_reg);
        end
    end
endmodule : tpf_mac_model
`default_nettype wire

//--- verif/test_tpf_top.sv
// Self-checking bench for the transmit front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_tpf_top;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_four_lane, i_ref_from_pin_b, i_ref_from_inter_block, i_ext_wr_clock_used;
    logic i_ref_clock_pin_a, i_ref_clock_pin_b, i_ref_inter_block, en, i_tx_valid, o_tx_ready;
    logic o_enc_valid, o_ref_selected, o_core_clk_en, o_core_clk_en_shared, o_core_clk_en_lane;
    logic o_par_clk_en, o_wr_from_lane0, o_clocks_stable;
    tpf_pkg::tpf_word_t i_tx_word;
    tpf_pkg::tpf_byte_t o_enc_byte;
    logic [7:0] sent, idx;
    int errors = 0, checks_done = 0;
    logic [1:0] sh, ln;
    // Mode and reference inputs, then expected selection and lane 0 write
    logic [8:0] rows [6] = '{9'h113, 9'h02c, 9'h0aa, 9'h195, 9'h047, 9'h1f8};
    always #4 i_clk_sys = ~i_clk_sys;
    tpf_top tpf_top_inst (.i_clk_sys, .i_rst_n, .i_four_lane, .i_ref_from_pin_b,
        .i_ref_from_inter_block, .i_ext_wr_clock_used, .i_ref_clock_pin_a, .i_ref_clock_pin_b,
        .i_ref_inter_block, .i_tx_valid, .o_tx_ready, .i_tx_word, .o_enc_byte, .o_enc_valid,
        .o_ref_selected, .o_core_clk_en, .o_core_clk_en_shared, .o_core_clk_en_lane,
        .o_par_clk_en, .o_wr_from_lane0, .o_clocks_stable);
    tpf_mac_model tpf_mac_model_inst (.i_clk_sys, .i_rst_n, .i_en(en), .i_tx_ready(o_tx_ready),
        .o_tx_valid(i_tx_valid), .o_tx_word(i_tx_word), .o_sent(sent));
    // Byte stream monitor
    always @(negedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) idx <= 8'h00;
        else if (o_enc_valid) begin
            `CHK("byte", {idx, idx[1] ^ idx[0]}, o_enc_byte)
            idx <= idx + 8'h01;
        end
    end
    task automatic conclude;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic stream;
        en <= 1'b1;
        repeat (60) @(negedge i_clk_sys);
        en <= 1'b0;
        repeat (30) @(negedge i_clk_sys);
        #1;
        `CHK("bytes", {sent, 1'b0}, {1'b0, idx})
        `CHK("rate", 1'b1, sent >= 8'h14)
    endtask : stream
    initial begin
        #100000;
        errors++;
        conclude();
    end
    initial begin
        {i_four_lane, i_ref_from_pin_b, i_ref_from_inter_block, i_ext_wr_clock_used} = 4'h0;
        {i_ref_clock_pin_a, i_ref_clock_pin_b, i_ref_inter_block} = 3'h0;
        en = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (15) begin
            @(negedge i_clk_sys);
            `CHK("ready in hold", 1'b0, o_tx_ready)
        end
        repeat (5) @(negedge i_clk_sys);
        `CHK("stable", 1'b1, o_clocks_stable)
        `CHK("par en", 1'b1, o_par_clk_en)
        `CHK("core rate", 125, tpf_pkg::CORE_MHZ)
        `CHK("par rate", 250, tpf_pkg::PAR_MHZ)
        foreach (rows[r]) begin
            {i_four_lane, i_ref_from_pin_b, i_ref_from_inter_block, i_ext_wr_clock_used,
                i_ref_clock_pin_a, i_ref_clock_pin_b, i_ref_inter_block} = rows[r][8:2];
            #1;
            `CHK("ref", rows[r][1], o_ref_selected)
            `CHK("lane0", rows[r][0], o_wr_from_lane0)
            sh = 2'h0;
            ln = 2'h0;
            repeat (2) begin
                @(negedge i_clk_sys);
                sh += {1'b0, o_core_clk_en_shared};
                ln += {1'b0, o_core_clk_en_lane};
            end
            `CHK("shared", {1'b0, i_four_lane}, sh)
            `CHK("lane", {1'b0, !i_four_lane}, ln)
        end
        stream();
        en <= 1'b1;
        repeat (30) @(negedge i_clk_sys);
        i_rst_n = 1'b0;
        #1;
        `CHK("valid in reset", 1'b0, o_enc_valid)
        `CHK("ready in reset", 1'b0, o_tx_ready)
        `CHK("par in reset", 1'b0, o_par_clk_en)
        @(negedge i_clk_sys);
        i_rst_n <= 1'b1;
        stream();
        conclude();
    end
endmodule : test_tpf_top
`default_nettype wire
